// ### shared/pmr_map.vh
// Offsets, field positions, reset values and frame constants of the
// per-port transceiver management register set.
// Assumes inclusion by its bare name from design and bench files.
`ifndef PMR_MAP_VH
`define PMR_MAP_VH

// ==================================================
// Register indices on the management interface
`define PMR_REG_BASIC_CONTROL    5'h00
`define PMR_REG_BASIC_STATUS     5'h01
`define PMR_REG_IDENT_UPPER      5'h02
`define PMR_REG_IDENT_LOWER      5'h03
`define PMR_REG_ADVERT           5'h04

// ==================================================
// Basic control fields
`define PMR_CTL_RENEGOTIATE      9
`define PMR_CTL_FULL_DUPLEX      8
`define PMR_CTL_XOVER_VARIANT    5
`define PMR_CTL_FORCED_PAIR      4
`define PMR_CTL_AUTO_XOVER_OFF   3
`define PMR_CTL_FAULT_DET_OFF    2
`define PMR_CTL_TRANSMIT_OFF     1
`define PMR_CTL_INDICATOR_OFF    0
`define PMR_CTL_WMASK            16'h033f
`define PMR_CTL_RESET            16'h0120

// ==================================================
// Basic status fields
`define PMR_STS_FIXED            16'h7808
`define PMR_STS_NEG_DONE         5
`define PMR_STS_FAR_FAULT        4
`define PMR_STS_LINK_UP          2

// ==================================================
// Advertisement fields
`define PMR_ADV_WMASK            16'h07e0
`define PMR_ADV_RESET            16'h05e0
`define PMR_ADV_FIXED            16'h0801
`define PMR_ADV_PAUSE            10
`define PMR_ADV_LSB              5

// ==================================================
// Serial management frame
`define PMR_MDIO_PREAMBLE        6'h20
`define PMR_MDIO_OP_READ         2'h2
`define PMR_MDIO_OP_WRITE        2'h1
`define PMR_MDIO_HDR_LAST        5'h0c
`define PMR_MDIO_DATA_LAST       5'h0f
`define PMR_PORT_FIRST           5'h01
`define PMR_PORT_LAST            5'h04

// ==================================================
// Serial peripheral bus frame
`define PMR_SPI_CMD_READ         8'h03
`define PMR_SPI_CMD_WRITE        8'h02
`define PMR_SPI_CMD_LAST         5'h07
`define PMR_SPI_ADDR_LAST        5'h0f
`define PMR_SPI_DATA_FIRST       5'h11
`define PMR_SPI_DATA_LAST        5'h17
`define PMR_SPI_DONE             5'h18

`endif

// ### src/pmr_phy_mgmt_regs.v
// Management register set of four 10/100 transceiver ports, reached over
// the serial management pins and over the serial peripheral bus.
// Assumes status inputs come from logic on clock_in; all pins are asynchronous.
//
// Operation
// - Writing one to control bit 9 restarts negotiation; bit resets to zero.
// - Control bit 8 forces full duplex when one, half when zero; resets one.
// - Control bit 5 picks alternate crossover variant when one, native when zero.
// - Control bit 4 forces straight mapping when one, crossed when zero.
// - Control bit 3 disables automatic crossover detection when one.
// - Control bit 2 turns off far end fault detection when one.
// - Control bit 1 stops the port transmitter when one.
// - Control bit 0 switches off the port indicator output when one.
// - Status bit 15 always reads zero, four-pair signalling unsupported.
// - Status bits 14 to 11 read one for the four speed/duplex abilities.
// - Status bit 5 reads one once negotiation has finished.
// - Status bit 4 reads one when a far end fault is detected.
// - Status bit 3 reads one, negotiation supported.
// - Status bit 2 reads one while link is up; follows link_up_in, no reset value.
// - Status bit 0 reads zero, no extended register set.
// - Registers two and three return fixed upper and lower identifier halves.
// - Advertisement bit 10 advertises pause ability; writable, resets one.
// - Advertisement bits 8 to 5 advertise speed/duplex abilities; writable, reset one.
// - Ports use transceiver addresses 1 to 4; only indices 0-4, others read zero.
// - Advertisement bits 4 to 0 read the fixed Ethernet selector value.
// - Every register is also reachable over the serial peripheral bus.

`timescale 1ns/1ps
`include "pmr_map.vh"

module pmr_phy_mgmt_regs #(
  parameter [15:0] IDENT_UPPER = 16'h1234,  // Arbitrary value
  parameter [15:0] IDENT_LOWER = 16'h5678   // Arbitrary value
) (
  input  wire        clock_in,
  input  wire        srst_in,
  input  wire        mdc_in,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe_out,
  input  wire        spi_sclk_in,
  input  wire        spi_sel_n_in,
  input  wire        spi_mosi_in,
  output wire        spi_miso_out,
  output reg         spi_miso_oe_out,
  input  wire [3:0]  link_up_in,
  input  wire [3:0]  negotiation_done_in,
  input  wire [3:0]  far_fault_in,
  output reg  [3:0]  renegotiate_trigger_out,
  output wire [3:0]  full_duplex_out,
  output wire [3:0]  crossover_variant_select_out,
  output wire [3:0]  forced_pair_mapping_out,
  output wire [3:0]  auto_crossover_off_out,
  output wire [3:0]  far_fault_detect_off_out,
  output wire [3:0]  transmit_off_out,
  output wire [3:0]  indicator_off_out,
  output wire [19:0] advert_ability_out
);

  // ==================================================
  // Register storage
  reg  [15:0] ctrl_reg [0:3];
  reg  [15:0] adv_reg  [0:3];

  function [15:0] rd_word;
    input [1:0] port;
    input [4:0] index;
    begin
      if (index == `PMR_REG_BASIC_CONTROL) begin
        rd_word = ctrl_reg[port] & `PMR_CTL_WMASK;
      end else if (index == `PMR_REG_BASIC_STATUS) begin
        rd_word = `PMR_STS_FIXED;
        rd_word[`PMR_STS_NEG_DONE]  = negotiation_done_in[port];
        rd_word[`PMR_STS_FAR_FAULT] = far_fault_in[port] &
                                      ~ctrl_reg[port][`PMR_CTL_FAULT_DET_OFF];
        rd_word[`PMR_STS_LINK_UP]   = link_up_in[port];
      end else if (index == `PMR_REG_IDENT_UPPER) begin
        rd_word = IDENT_UPPER;
      end else if (index == `PMR_REG_IDENT_LOWER) begin
        rd_word = IDENT_LOWER;
      end else if (index == `PMR_REG_ADVERT) begin
        rd_word = (adv_reg[port] & `PMR_ADV_WMASK) | `PMR_ADV_FIXED;
      end else begin
        // Partner ability and diagnostics live elsewhere; read as zero
        rd_word = 16'h0000;
      end
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [15:0] dat;
    input [15:0] mask;
    begin
      merge = (old & ~mask) | (dat & mask);
    end
  endfunction

  // Byte lane of a word for the byte-wide serial bus
  function [7:0] pick_byte;
    input [15:0] word;
    input        hi;
    begin
      pick_byte = hi ? word[15:8] : word[7:0];
    end
  endfunction

  // ==================================================
  // Pin synchronisers and edge detection
  reg  [2:0] mdc_sync;
  reg  [1:0] mdio_sync;
  reg  [2:0] sclk_sync;
  reg  [1:0] sel_n_sync;
  reg  [1:0] mosi_sync;

  always @(posedge clock_in) begin
    if (srst_in) begin
      mdc_sync   <= 3'h0;
      mdio_sync  <= 2'h0;
      sclk_sync  <= 3'h0;
      sel_n_sync <= 2'h3;
      mosi_sync  <= 2'h0;
    end else begin
      mdc_sync   <= {mdc_sync[1:0], mdc_in};
      mdio_sync  <= {mdio_sync[0], mdio_in};
      sclk_sync  <= {sclk_sync[1:0], spi_sclk_in};
      sel_n_sync <= {sel_n_sync[0], spi_sel_n_in};
      mosi_sync  <= {mosi_sync[0], spi_mosi_in};
    end
  end

  // Data and clock see equal delay, so sampling stays aligned
  wire mdc_rise   = mdc_sync[1] & ~mdc_sync[2];
  wire mdio_bit   = mdio_sync[1];
  wire sclk_rise  = sclk_sync[1] & ~sclk_sync[2];
  wire sclk_fall  = ~sclk_sync[1] & sclk_sync[2];
  wire spi_active = ~sel_n_sync[1];
  wire mosi_bit   = mosi_sync[1];

  // ==================================================
  // Serial management frame engine
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_HDR  = 4'b0010;
  localparam [3:0] ST_TURN = 4'b0100;
  localparam [3:0] ST_DATA = 4'b1000;

  reg  [3:0]  md_state;
  reg  [5:0]  ones_cnt;
  reg  [4:0]  bit_cnt;
  reg  [11:0] hdr_sh;
  reg  [15:0] md_sh;
  reg         md_read;
  reg  [1:0]  md_port;
  reg  [4:0]  md_index;
  reg         mw_en;

  wire [12:0] frame     = {hdr_sh, mdio_bit};
  wire [4:0]  frame_pa  = frame[9:5];
  wire        port_hit  = (frame_pa >= `PMR_PORT_FIRST) && (frame_pa <= `PMR_PORT_LAST);
  wire [4:0]  pa_less   = frame_pa - `PMR_PORT_FIRST;

  always @(posedge clock_in) begin
    if (srst_in) begin
      md_state    <= ST_IDLE;
      ones_cnt    <= 6'h00;
      bit_cnt     <= 5'h00;
      hdr_sh      <= 12'h000;
      md_sh       <= 16'h0000;
      md_read     <= 1'b0;
      md_port     <= 2'h0;
      md_index    <= 5'h00;
      mw_en       <= 1'b0;
      mdio_out    <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else begin
      mw_en <= 1'b0;
      if (mdc_rise) begin
        case (md_state)
          ST_IDLE: begin
            if (mdio_bit) begin
              if (ones_cnt != `PMR_MDIO_PREAMBLE) begin
                ones_cnt <= ones_cnt + 6'h01;
              end
            end else begin
              // First start bit only counts after a full preamble
              if (ones_cnt == `PMR_MDIO_PREAMBLE) begin
                md_state <= ST_HDR;
                bit_cnt  <= 5'h00;
              end
              ones_cnt <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr_sh  <= frame[11:0];
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `PMR_MDIO_HDR_LAST) begin
              bit_cnt  <= 5'h00;
              md_port  <= pa_less[1:0];
              md_index <= frame[4:0];
              md_read  <= (frame[11:10] == `PMR_MDIO_OP_READ);
              if (frame[12] && port_hit &&
                  (frame[11:10] == `PMR_MDIO_OP_READ ||
                   frame[11:10] == `PMR_MDIO_OP_WRITE)) begin
                md_state <= ST_TURN;
              end else begin
                md_state <= ST_IDLE;
              end
            end
          end
          ST_TURN: begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h00) begin
              if (md_read) begin
                mdio_oe_out <= 1'b1;
                mdio_out    <= 1'b0;
                md_sh       <= rd_word(md_port, md_index);
              end
            end else begin
              md_state <= ST_DATA;
              bit_cnt  <= 5'h00;
              if (md_read) begin
                mdio_out <= md_sh[15];
                md_sh    <= {md_sh[14:0], 1'b0};
              end
            end
          end
          ST_DATA: begin
            bit_cnt <= bit_cnt + 5'h01;
            if (md_read) begin
              mdio_out <= md_sh[15];
              md_sh    <= {md_sh[14:0], 1'b0};
            end else begin
              md_sh <= {md_sh[14:0], mdio_bit};
            end
            if (bit_cnt == `PMR_MDIO_DATA_LAST) begin
              md_state    <= ST_IDLE;
              mdio_oe_out <= 1'b0;
              mdio_out    <= 1'b0;
              mw_en       <= ~md_read;
            end
          end
          default: begin
            md_state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==================================================
  // Serial peripheral bus engine (mode 0, one byte per frame)
  // Address byte: port [7:6], register index [5:1], high byte [0]
  reg  [4:0] spi_cnt;
  reg  [7:0] spi_cmd;
  reg  [7:0] spi_addr;
  reg  [7:0] spi_sh;
  reg  [7:0] spi_out;
  reg        sw_en;

  wire [7:0]  spi_next  = {spi_sh[6:0], mosi_bit};

  assign spi_miso_out = spi_out[7];

  always @(posedge clock_in) begin
    if (srst_in) begin
      spi_cnt         <= 5'h00;
      spi_cmd         <= 8'h00;
      spi_addr        <= 8'h00;
      spi_sh          <= 8'h00;
      spi_out         <= 8'h00;
      spi_miso_oe_out <= 1'b0;
      sw_en           <= 1'b0;
    end else begin
      sw_en <= 1'b0;
      if (!spi_active) begin
        spi_cnt         <= 5'h00;
        spi_miso_oe_out <= 1'b0;
      end else if (sclk_rise && spi_cnt != `PMR_SPI_DONE) begin
        spi_sh  <= spi_next;
        spi_cnt <= spi_cnt + 5'h01;
        if (spi_cnt == `PMR_SPI_CMD_LAST) begin
          spi_cmd <= spi_next;
        end
        if (spi_cnt == `PMR_SPI_ADDR_LAST) begin
          spi_addr <= spi_next;
          if (spi_cmd == `PMR_SPI_CMD_READ) begin
            // Word formed at the sampling edge so live status bits are current
            spi_out         <= pick_byte(rd_word(spi_next[7:6], spi_next[5:1]),
                                         spi_next[0]);
            spi_miso_oe_out <= 1'b1;
          end
        end
        if (spi_cnt == `PMR_SPI_DATA_LAST) begin
          sw_en <= (spi_cmd == `PMR_SPI_CMD_WRITE);
        end
      end else if (sclk_fall && spi_miso_oe_out && spi_cnt >= `PMR_SPI_DATA_FIRST) begin
        spi_out <= {spi_out[6:0], 1'b0};
      end
    end
  end

  // ==================================================
  // Register writes; a management write lands after a bus write to the same bits
  wire [15:0] sw_mask = spi_addr[0] ? 16'hff00 : 16'h00ff;
  wire [15:0] sw_data = {spi_sh, spi_sh};
  integer p;

  always @(posedge clock_in) begin
    if (srst_in) begin
      for (p = 0; p < 4; p = p + 1) begin
        ctrl_reg[p] <= `PMR_CTL_RESET;
        adv_reg[p]  <= `PMR_ADV_RESET;
      end
      renegotiate_trigger_out <= 4'h0;
    end else begin
      renegotiate_trigger_out <= 4'h0;
      if (sw_en) begin
        if (spi_addr[5:1] == `PMR_REG_BASIC_CONTROL) begin
          ctrl_reg[spi_addr[7:6]] <= merge(ctrl_reg[spi_addr[7:6]], sw_data,
                                           sw_mask & `PMR_CTL_WMASK);
          if (sw_mask[`PMR_CTL_RENEGOTIATE] && sw_data[`PMR_CTL_RENEGOTIATE]) begin
            renegotiate_trigger_out[spi_addr[7:6]] <= 1'b1;
          end
        end else if (spi_addr[5:1] == `PMR_REG_ADVERT) begin
          adv_reg[spi_addr[7:6]] <= merge(adv_reg[spi_addr[7:6]], sw_data,
                                          sw_mask & `PMR_ADV_WMASK);
        end
      end
      if (mw_en) begin
        if (md_index == `PMR_REG_BASIC_CONTROL) begin
          ctrl_reg[md_port] <= merge(ctrl_reg[md_port], md_sh, `PMR_CTL_WMASK);
          if (md_sh[`PMR_CTL_RENEGOTIATE]) begin
            renegotiate_trigger_out[md_port] <= 1'b1;
          end
        end else if (md_index == `PMR_REG_ADVERT) begin
          adv_reg[md_port] <= merge(adv_reg[md_port], md_sh, `PMR_ADV_WMASK);
        end
      end
    end
  end

  // ==================================================
  // Per-port controls to the transceiver
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : port_ctl
      assign full_duplex_out[g]              = ctrl_reg[g][`PMR_CTL_FULL_DUPLEX];
      assign crossover_variant_select_out[g] = ctrl_reg[g][`PMR_CTL_XOVER_VARIANT];
      assign forced_pair_mapping_out[g]      = ctrl_reg[g][`PMR_CTL_FORCED_PAIR];
      assign auto_crossover_off_out[g]       = ctrl_reg[g][`PMR_CTL_AUTO_XOVER_OFF];
      assign far_fault_detect_off_out[g]     = ctrl_reg[g][`PMR_CTL_FAULT_DET_OFF];
      assign transmit_off_out[g]             = ctrl_reg[g][`PMR_CTL_TRANSMIT_OFF];
      assign indicator_off_out[g]            = ctrl_reg[g][`PMR_CTL_INDICATOR_OFF];
      // Pause, 100 full, 100 half, 10 full, 10 half
      assign advert_ability_out[g*5 +: 5]    = {adv_reg[g][`PMR_ADV_PAUSE],
                                                adv_reg[g][8:`PMR_ADV_LSB]};
    end
  endgenerate

endmodule

// ### testbench/pmr_regs_assertions.sv
// Checker on the ports of the management register set.
// Assumes the bind in the bench top file; one clock domain.
`timescale 1ns/1ps
module pmr_regs_assertions (
  input logic        clock_in,
  input logic        srst_in,
  input logic        mdc_in,
  input logic        mdio_out,
  input logic        mdio_oe_out,
  input logic        spi_sclk_in,
  input logic        spi_sel_n_in,
  input logic        spi_miso_out,
  input logic        spi_miso_oe_out,
  input logic [3:0]  renegotiate_trigger_out,
  input logic [3:0]  full_duplex_out,
  input logic [3:0]  crossover_variant_select_out,
  input logic [3:0]  forced_pair_mapping_out,
  input logic [3:0]  auto_crossover_off_out,
  input logic [3:0]  far_fault_detect_off_out,
  input logic [3:0]  transmit_off_out,
  input logic [3:0]  indicator_off_out,
  input logic [19:0] advert_ability_out
);
  // ==================================================
  // Properties
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  chk_pulse_one_cycle: assert property (|renegotiate_trigger_out |=>
    renegotiate_trigger_out == 4'h0) else $error("restart pulse too long");
  chk_ctl_reset_val: assert property ($fell(srst_in) |-> ({full_duplex_out,
    crossover_variant_select_out, forced_pair_mapping_out, auto_crossover_off_out,
    far_fault_detect_off_out, transmit_off_out, indicator_off_out} == 28'hff00000))
    else $error("control outputs wrong after reset");
  chk_adv_reset_val: assert property ($fell(srst_in) |->
    advert_ability_out == 20'hfffff) else $error("advert outputs wrong after reset");
  chk_turn_low: assert property ($rose(mdio_oe_out) |-> !mdio_out [*8])
    else $error("turnaround bit not low");
  chk_read_span: assert property ($rose(mdio_oe_out) |-> ##[540:548]
    $fell(mdio_oe_out)) else $error("read drive span wrong");
  // Data may only move while the management clock is high, after its rise
  chk_mdio_hold: assert property (mdio_oe_out && $past(mdio_oe_out) &&
    $changed(mdio_out) |-> mdc_in && $past(mdc_in)) else $error("mdio moved off rise");
  chk_spi_release: assert property (spi_sel_n_in [*6] |-> !spi_miso_oe_out)
    else $error("miso driven while deselected");
  chk_miso_on_fall: assert property (spi_miso_oe_out && $past(spi_miso_oe_out) &&
    $changed(spi_miso_out) |-> !spi_sclk_in) else $error("miso moved while sclk high");
endmodule

// ### testbench/pmr_mdio_host.sv
// Management host model: drives clause-22 style frames on the serial pins.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
module pmr_mdio_host (
  output logic mdc_out,
  output logic drv_out,
  output logic drv_oe_out,
  input  logic line_in
);
  localparam int HALF = 80;
  // Clock rests low between frames
  initial begin
    mdc_out = 1'b0;
    drv_out = 1'b1;
    drv_oe_out = 1'b0;
  end
  task automatic bit_out(input logic b);
    drv_oe_out = 1'b1;
    drv_out = b;
    #HALF mdc_out = 1'b1;
    #HALF mdc_out = 1'b0;
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] adr, input logic [4:0] idx,
                      input logic [15:0] wdat, output logic [15:0] rdat);
    logic [45:0] hdr;
    logic [17:0] tail;
    hdr = {32'hffffffff, 2'b01, op, adr, idx};
    tail = {2'b10, wdat};
    rdat = 16'h0000;
    for (int i = 45; i >= 0; i--) bit_out(hdr[i]);
    if (op == 2'b01) begin
      for (int i = 17; i >= 0; i--) bit_out(tail[i]);
    end else begin
      drv_oe_out = 1'b0;
      // Sample at each rise; the device moves a few cycles after it
      for (int i = 17; i >= 0; i--) begin
        #HALF mdc_out = 1'b1;
        if (i < 16) rdat[i] = line_in;
        #HALF mdc_out = 1'b0;
      end
    end
    drv_oe_out = 1'b0;
  endtask
endmodule

// ### testbench/pmr_phy_mgmt_regs_tb.sv
// Self-checking bench for the management register set.
// Assumes the host model and the checker files are compiled before it.
`timescale 1ns/1ps
`include "pmr_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module pmr_phy_mgmt_regs_tb;
  logic        clock_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        mdc, drv, drv_oe, mdio_out, mdio_oe;
  logic        sclk = 1'b0;
  logic        sel_n = 1'b1;
  logic        mosi = 1'b0;
  logic        miso, miso_oe;
  logic [3:0]  link_up = 4'h0;
  logic [3:0]  neg_done = 4'h0;
  logic [3:0]  far_fault = 4'h0;
  logic [3:0]  trig, fd, xv, fp, ax, ff, tx, ind;
  logic [3:0]  seen = 4'h0;
  logic [19:0] adv;
  logic [7:0]  r8;
  int          n_mismatch = 0;
  int          compares = 0;
  // Pull-up holds the shared line when nobody drives it
  wire mdio_line = drv_oe ? drv : (mdio_oe ? mdio_out : 1'b1);
  wire miso_line = miso_oe ? miso : 1'bz;
  always #2.5 clock_in = ~clock_in;
  always @(posedge clock_in) seen <= seen | trig;
  pmr_mdio_host host (.mdc_out(mdc), .drv_out(drv), .drv_oe_out(drv_oe), .line_in(mdio_line));
  pmr_phy_mgmt_regs uut (.clock_in(clock_in), .srst_in(srst_in), .mdc_in(mdc),
    .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe), .spi_sclk_in(sclk),
    .spi_sel_n_in(sel_n), .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
    .link_up_in(link_up), .negotiation_done_in(neg_done), .far_fault_in(far_fault),
    .renegotiate_trigger_out(trig), .full_duplex_out(fd), .crossover_variant_select_out(xv),
    .forced_pair_mapping_out(fp), .auto_crossover_off_out(ax), .far_fault_detect_off_out(ff),
    .transmit_off_out(tx), .indicator_off_out(ind), .advert_ability_out(adv));
  // ==================================================
  // Access tasks
  task automatic rd(input logic [4:0] port, input logic [4:0] idx, input logic [15:0] e);
    logic [15:0] d;
    // Frames start just after a clock edge, like all other stimulus
    @(posedge clock_in) #1;
    host.xfer(`PMR_MDIO_OP_READ, port, idx, 16'h0000, d);
    `CHK(d, e)
  endtask
  task automatic wr(input logic [4:0] port, input logic [4:0] idx, input logic [15:0] w);
    logic [15:0] d;
    @(posedge clock_in) #1;
    host.xfer(`PMR_MDIO_OP_WRITE, port, idx, w, d);
  endtask
  task automatic spi(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] w,
                     output logic [7:0] r);
    logic [23:0] s;
    s = {cmd, adr, w};
    @(posedge clock_in) #1 sel_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi = s[i];
      #80 sclk = 1'b1;
      if (i < 8) r[i] = miso_line;
      #80 sclk = 1'b0;
    end
    #80 sel_n = 1'b1;
    mosi = ~mosi;
    // Deselect stands for many clocks so the device sees the frame end
    #80;
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
  // ==================================================
  // Tests
  initial begin
    repeat (2) @(posedge clock_in);
    #1 srst_in = 1'b0;
    repeat (4) @(posedge clock_in);
    for (int p = 1; p <= 4; p++) rd(p[4:0], `PMR_REG_BASIC_CONTROL, 16'h0120);
    rd(5'h01, `PMR_REG_IDENT_UPPER, 16'h1234);
    rd(5'h01, `PMR_REG_IDENT_LOWER, 16'h5678);
    rd(5'h01, `PMR_REG_ADVERT, 16'h0de1);
    @(posedge clock_in) #1 link_up = 4'b0010;
    neg_done = 4'b0010;
    far_fault = 4'b0010;
    rd(5'h02, `PMR_REG_BASIC_STATUS, 16'h783c);
    rd(5'h01, `PMR_REG_BASIC_STATUS, 16'h7808);
    wr(5'h02, `PMR_REG_BASIC_CONTROL, 16'h0004);
    rd(5'h02, `PMR_REG_BASIC_STATUS, 16'h782c);
    wr(5'h03, `PMR_REG_BASIC_CONTROL, 16'hffff);
    rd(5'h03, `PMR_REG_BASIC_CONTROL, 16'h033f);
    `CHK(seen, 4'b0100)
    wr(5'h04, `PMR_REG_ADVERT, 16'h0000);
    rd(5'h04, `PMR_REG_ADVERT, 16'h0801);
    `CHK(adv, 20'h07fff)
    // Out-of-range port and read-only register must both be left alone
    wr(5'h05, `PMR_REG_BASIC_CONTROL, 16'h0000);
    wr(5'h01, `PMR_REG_BASIC_STATUS, 16'hffff);
    rd(5'h01, `PMR_REG_BASIC_CONTROL, 16'h0120);
    rd(5'h01, `PMR_REG_BASIC_STATUS, 16'h7808);
    rd(5'h01, 5'h05, 16'h0000);
    spi(`PMR_SPI_CMD_WRITE, 8'h00, 8'h1f, r8);
    spi(`PMR_SPI_CMD_READ, 8'h00, 8'h00, r8);
    `CHK(r8, 8'h1f)
    spi(`PMR_SPI_CMD_READ, 8'h05, 8'h00, r8);
    `CHK(r8, 8'h12)
    rd(5'h01, `PMR_REG_BASIC_CONTROL, 16'h011f);
    `CHK({fd, xv, fp, ax, ff, tx, ind}, 28'hdc55755)
    // High byte restart on port 4, advert low byte on port 2, live status read
    spi(`PMR_SPI_CMD_WRITE, 8'hc1, 8'h02, r8);
    spi(`PMR_SPI_CMD_WRITE, 8'h48, 8'h00, r8);
    spi(`PMR_SPI_CMD_READ, 8'h42, 8'h00, r8);
    `CHK(r8, 8'h2c)
    `CHK({seen, fd[3]}, 5'b11000)
    `CHK(adv, 20'h07f1f)
    close_out();
  end
endmodule
bind pmr_phy_mgmt_regs pmr_regs_assertions chk (.clock_in(clock_in), .srst_in(srst_in),
  .mdc_in(mdc_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out),
  .spi_sclk_in(spi_sclk_in), .spi_sel_n_in(spi_sel_n_in), .spi_miso_out(spi_miso_out),
  .spi_miso_oe_out(spi_miso_oe_out), .renegotiate_trigger_out(renegotiate_trigger_out),
  .full_duplex_out(full_duplex_out), .crossover_variant_select_out(crossover_variant_select_out),
  .forced_pair_mapping_out(forced_pair_mapping_out),
  .auto_crossover_off_out(auto_crossover_off_out),
  .far_fault_detect_off_out(far_fault_detect_off_out), .transmit_off_out(transmit_off_out),
  .indicator_off_out(indicator_off_out), .advert_ability_out(advert_ability_out));
